//--- mmd_map.vh
`ifndef MMD_MAP_VH
`define MMD_MAP_VH
// ----------------------------------------
// Mode encodings {high, low}
// ----------------------------------------
`define MMD_MODE_BOOT      2'h0
`define MMD_MODE_SINGLE    2'h1
`define MMD_MODE_TEST      2'h2
`define MMD_MODE_EXPANDED  2'h3
// ----------------------------------------
// Memory map constants
// ----------------------------------------
`define MMD_REG_BYTES      16'h0060
`define MMD_RAM_BYTES      16'h0400
`define MMD_EE_BYTES       16'h0200
`define MMD_EE_OFFSET      12'hE00
`define MMD_EE_DEF_PAGE    4'hF
`define MMD_REG_RST_PAGE   4'h1
`define MMD_RAM_RST_PAGE   4'h0
`define MMD_BOOT_BASE      16'hBF00
`define MMD_BOOT_VEC_BASE  16'hBFC0
`define MMD_NORM_VEC_BASE  16'hFFC0
`define MMD_RAM_LAST       16'h03FF
`define MMD_RAM_ENTRY      16'h0000
`define MMD_IDLE_CHARS     4'h4
// ----------------------------------------
// Avalon register offsets (byte addresses) and fields
// ----------------------------------------
`define MMD_OFS_MAPPOS     4'h0
`define MMD_OFS_CONFIG     4'h4
`define MMD_OFS_STATUS     4'h8
`define MMD_OFS_ACCESS     4'hC
`define MMD_MAPPOS_RST     8'h01
`define MMD_CONFIG_RST     8'hF1
`define MMD_CFG_EEON_BIT   0
`define MMD_OR_BIT         8
`endif

//--- mmd_cfg_store.v
`timescale 1ns/1ps
`include "mmd_map.vh"
// Nonvolatile configuration byte, kept apart from the EEPROM array.
// Write is accepted only when the enclosing logic grants privilege.
module mmd_cfg_store #(
    parameter [7:0] RESET_VALUE = `MMD_CONFIG_RST
) (
    clk,
    rst,
    ce,
    wrEn,
    wrData,
    rdData
);
    input  wire       clk;
    input  wire       rst;
    input  wire       ce;
    input  wire       wrEn;
    input  wire [7:0] wrData;
    output wire [7:0] rdData;

    reg [7:0] cell_q;

    // --------------------------------------------------------------
    // Storage cell
    // --------------------------------------------------------------
    // Reset stands in for the erased/factory content of the cell
    always @(posedge clk) begin
        if (rst) begin
            cell_q <= RESET_VALUE;
        end else if (ce && wrEn) begin
            cell_q <= wrData;
        end
    end

    assign rdData = cell_q;
endmodule // mmd_cfg_store

//--- mmd_mode_map.v
`timescale 1ns/1ps
`include "mmd_map.vh"

// Notes on behaviour
// - Mode pins are captured while reset is held; captured pair sets mode.
// - Single-chip: no external bus; ports B, C, F are general I/O.
// - Expanded: full 64-Kbyte space; unclaimed addresses go external.
// - Expanded bus: high address on B, low address on F, data on C.
// - Read/write output marks port C direction; outside parts follow it.
// - Test mode keeps expanded bus and allows config and calibration writes.
// - Bootstrap: vectors come from boot ROM top 64 bytes.
// - Loader takes up to 1024 bytes; jumps to zero on idle or last byte.
// - Loader makes port D open-drain; transmit pin needs external pull-up.
// - Bootstrap interrupt vectors point into RAM via a jump table.
// - Registers and RAM decode identically in expanded and single-chip modes; EEPROM place and enable differ.
// - Register block at 0x1000 after reset; relocatable on 4-Kbyte pages.
// - RAM at zero after reset; relocatable on 4-Kbyte pages.
// - Registers win over RAM in a shared page; low 96 RAM bytes hidden.
// - Expanded: EEPROM at 0xFE00 after reset when the config byte enables it.
// - Expanded and test: EEPROM at page field, offset 0xE00.
// - Single-chip and bootstrap: EEPROM forced on at default place.
// - Bootstrap: boot ROM claims all of 0xBF00 to 0xBFFF.
// - Configuration byte is a separate cell outside the EEPROM array.
// - RAM page equals RAM field of map-position register.
// - Register page equals register field of map-position register.
// - Boot ROM is absent from the map in normal modes.
// - Test mode: EEPROM starts disabled after reset.
module mmd_mode_map (
    clk,
    rst,
    ce,
    modeSelHigh,
    modeSelLow,
    avsAddress,
    avsRead,
    avsWrite,
    avsWriteData,
    avsReadData,
    avsWaitRequest,
    cpuAddr,
    cpuValid,
    cpuWrite,
    cpuWrData,
    cpuRdData,
    cpuAckPulse,
    portBOut,
    portFOut,
    portCOut,
    portCOe,
    portCIn,
    gpioB,
    gpioF,
    gpioCOut,
    gpioCOe,
    gpioCIn,
    rdWrN,
    selReg,
    selRam,
    selEe,
    selBoot,
    selExt,
    vectorBase,
    portDOpenDrain,
    modeOut
);
    input  wire        clk;
    input  wire        rst;
    input  wire        ce;
    input  wire        modeSelHigh;
    input  wire        modeSelLow;
    input  wire [3:0]  avsAddress;
    input  wire        avsRead;
    input  wire        avsWrite;
    input  wire [31:0] avsWriteData;
    output reg  [31:0] avsReadData;
    output wire        avsWaitRequest;
    input  wire [15:0] cpuAddr;
    input  wire        cpuValid;
    input  wire        cpuWrite;
    input  wire [7:0]  cpuWrData;
    output reg  [7:0]  cpuRdData;
    output reg         cpuAckPulse;
    output reg  [7:0]  portBOut;
    output reg  [7:0]  portFOut;
    output reg  [7:0]  portCOut;
    output reg         portCOe;
    input  wire [7:0]  portCIn;
    input  wire [7:0]  gpioB;
    input  wire [7:0]  gpioF;
    input  wire [7:0]  gpioCOut;
    input  wire        gpioCOe;
    output wire [7:0]  gpioCIn;
    output reg         rdWrN;
    output wire        selReg;
    output wire        selRam;
    output wire        selEe;
    output wire        selBoot;
    output wire        selExt;
    output wire [15:0] vectorBase;
    output wire        portDOpenDrain;
    output wire [1:0]  modeOut;

    // --------------------------------------------------------------
    // Pin synchronisers and mode capture
    // --------------------------------------------------------------
    reg  [1:0] pinMeta_q;
    reg  [1:0] pinSync_q;
    reg  [7:0] portCMeta_q;
    reg  [7:0] portCSync_q;
    reg  [1:0] mode_q;
    reg        cfgUnlocked_q;

    // Two stages before anything reads the straps or the data bus
    always @(posedge clk) begin
        if (ce) begin
            pinMeta_q   <= {modeSelHigh, modeSelLow};
            pinSync_q   <= pinMeta_q;
            portCMeta_q <= portCIn;
            portCSync_q <= portCMeta_q;
        end
    end

    // Straps tracked during reset; value at release is the one kept
    always @(posedge clk) begin
        if (ce && rst) begin
            mode_q <= pinSync_q;
        end
    end

    wire isBoot   = (mode_q == `MMD_MODE_BOOT);
    wire isSingle = (mode_q == `MMD_MODE_SINGLE);
    wire isTest   = (mode_q == `MMD_MODE_TEST);
    wire isExp    = (mode_q == `MMD_MODE_EXPANDED);
    wire busMode  = isExp | isTest;
    assign modeOut = mode_q;

    // --------------------------------------------------------------
    // Map-position and configuration state
    // --------------------------------------------------------------
    reg  [7:0] mapPos_q;
    reg  [7:0] cfgTestEe_q;
    wire [7:0] cfgByte;
    wire       cfgWrEn;
    wire [3:0] ramPage = mapPos_q[7:4];
    wire [3:0] regPage = mapPos_q[3:0];
    wire [3:0] eeprom_page_field = cfgByte[7:4];

    // Configuration cell written only in test mode; the unlock flag is not needed
    assign cfgWrEn = avsWrite && (avsAddress == `MMD_OFS_CONFIG) && isTest;

    mmd_cfg_store #(
        .RESET_VALUE (`MMD_CONFIG_RST)
    ) uCfg (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .wrEn   (cfgWrEn),
        .wrData (avsWriteData[7:0]),
        .rdData (cfgByte)
    );

    // Test mode holds the array off until software enables it
    always @(posedge clk) begin
        if (rst) begin
            cfgTestEe_q   <= 8'h00;
            cfgUnlocked_q <= 1'b0;
        end else if (ce && avsWrite && (avsAddress == `MMD_OFS_ACCESS) && isTest) begin
            cfgTestEe_q   <= avsWriteData[7:0];
            cfgUnlocked_q <= 1'b1;
        end
    end

    // Map position; RAM and registers default to zero and 0x1000
    always @(posedge clk) begin
        if (rst) begin
            mapPos_q <= `MMD_MAPPOS_RST;
        end else if (ce && avsWrite && (avsAddress == `MMD_OFS_MAPPOS)) begin
            mapPos_q <= avsWriteData[7:0];
        end
    end

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------
    wire [3:0]  aPage = cpuAddr[15:12];
    wire [11:0] aOfs  = cpuAddr[11:0];
    wire        eeOn;
    wire [3:0]  eePage;

    // Forced on at default place in single-chip and bootstrap
    assign eeOn   = (isSingle | isBoot) ? 1'b1 :
                    isTest ? cfgTestEe_q[`MMD_CFG_EEON_BIT] :
                    cfgByte[`MMD_CFG_EEON_BIT];
    assign eePage = busMode ? eeprom_page_field : `MMD_EE_DEF_PAGE;

    // Map constants cut to the bits that each compare really uses.
    // The EEPROM spans 512 bytes, so three offset bits place it;
    // the boot ROM spans 256 bytes, so the high address byte places it.
    localparam [11:0] EE_OFS    = `MMD_EE_OFFSET;
    localparam [15:0] BOOT_BASE = `MMD_BOOT_BASE;
    localparam [2:0]  EE_OFS_HI = EE_OFS[11:9];
    localparam [7:0]  BOOT_HI   = BOOT_BASE[15:8];

    // Same decode in every mode apart from boot ROM and EEPROM place and enable
    wire hitReg  = (aPage == regPage) && ({4'h0, aOfs} < `MMD_REG_BYTES);
    wire hitRam  = (aPage == ramPage) && ({4'h0, aOfs} < `MMD_RAM_BYTES);
    wire hitEe   = eeOn && (aPage == eePage) && (aOfs[11:9] == EE_OFS_HI);
    wire hitBoot = isBoot && (cpuAddr[15:8] == BOOT_HI);

    // Priority: registers over RAM, then ROM, EEPROM, external
    assign selReg  = cpuValid && hitReg;
    assign selRam  = cpuValid && hitRam && !hitReg;
    assign selBoot = cpuValid && hitBoot && !hitReg && !hitRam;
    assign selEe   = cpuValid && hitEe && !hitReg && !hitRam && !hitBoot;
    assign selExt  = cpuValid && busMode && !(hitReg | hitRam | hitBoot | hitEe);

    // Vectors come from boot ROM top block only in bootstrap
    assign vectorBase     = isBoot ? `MMD_BOOT_VEC_BASE : `MMD_NORM_VEC_BASE;
    // Loader drives port D wired-OR; the pull-up is outside
    assign portDOpenDrain = isBoot;

    // --------------------------------------------------------------
    // Expansion bus engine
    // --------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_HOLD = 2'h3;
    reg  [1:0] st_q;

    // Cycle: IDLE takes the request and puts out address and direction,
    // ADDR and HOLD give the far side time and let the returned byte pass
    // both synchroniser stages, DATA takes the byte and acks.
    // A request still up in the ack cycle is not taken again, so the core
    // drops valid on the edge that samples the ack; a shorter cycle would
    // hand back whatever the data pins showed for the previous address.
    always @(posedge clk) begin
        if (rst) begin
            st_q        <= ST_IDLE;
            portBOut    <= 8'h00;
            portFOut    <= 8'h00;
            portCOut    <= 8'h00;
            portCOe     <= 1'b0;
            rdWrN       <= 1'b1;
            cpuRdData   <= 8'h00;
            cpuAckPulse <= 1'b0;
        end else if (ce) begin
            cpuAckPulse <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (busMode) begin
                        if (selExt && !cpuAckPulse) begin
                            portBOut <= cpuAddr[15:8];
                            portFOut <= cpuAddr[7:0];
                            rdWrN    <= !cpuWrite;
                            portCOut <= cpuWrData;
                            portCOe  <= cpuWrite;
                            st_q     <= ST_ADDR;
                        end else begin
                            portCOe <= 1'b0;
                            rdWrN   <= 1'b1;
                        end
                    end else begin
                        // No bus: pins belong to general I/O
                        portBOut <= gpioB;
                        portFOut <= gpioF;
                        portCOut <= gpioCOut;
                        portCOe  <= gpioCOe;
                        rdWrN    <= 1'b1;
                    end
                end
                ST_ADDR: begin
                    // Far side sees a stable address from here on
                    st_q <= ST_HOLD;
                end
                ST_HOLD: begin
                    st_q <= ST_DATA;
                end
                ST_DATA: begin
                    // Both sync stages now hold the byte for this address
                    cpuRdData   <= portCSync_q;
                    cpuAckPulse <= 1'b1;
                    portCOe     <= 1'b0;
                    rdWrN       <= 1'b1;
                    st_q        <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign gpioCIn = portCSync_q;

    // --------------------------------------------------------------
    // Avalon slave: writes take no wait, reads take one
    // --------------------------------------------------------------
    // Read data come from a register, so the first read edge loads it
    // and waitrequest keeps the master waiting until the word stands;
    // a zero-wait read would hand the master the previous read's word
    reg         rdDone_q;
    reg  [31:0] rdMux;
    wire [31:0] statusWord;

    assign avsWaitRequest = avsRead && !rdDone_q;

    // Status: mode, EEPROM page, boot, EEPROM on, two spare, unlocked
    assign statusWord = {21'h000000, cfgUnlocked_q, 2'h0, eeOn, isBoot, eePage, mode_q};

    // Register select for reads; unmapped offsets read as zero
    always @* begin
        case (avsAddress)
            `MMD_OFS_MAPPOS: rdMux = {24'h000000, mapPos_q};
            `MMD_OFS_CONFIG: rdMux = {24'h000000, cfgByte};
            `MMD_OFS_STATUS: rdMux = statusWord;
            `MMD_OFS_ACCESS: rdMux = {24'h000000, cfgTestEe_q};
            default:         rdMux = 32'h0000_0000;
        endcase
    end

    // First read edge loads the word, the next one lets the master take it
    always @(posedge clk) begin
        if (rst) begin
            avsReadData <= 32'h0000_0000;
            rdDone_q    <= 1'b0;
        end else if (ce) begin
            if (avsRead && !rdDone_q) begin
                avsReadData <= rdMux;
                rdDone_q    <= 1'b1;
            end else begin
                rdDone_q    <= 1'b0;
            end
        end
    end

    // Loader sequencing runs as firmware; the decode above only
    // keeps its RAM window reachable from zero up to the last RAM byte.
    // The idle timeout and byte count live in that firmware, not here.
endmodule // mmd_mode_map

//--- mmd_mode_map_properties.sv
`timescale 1ns/1ps
module mmd_map_checker (
    input wire        clk,
    input wire        rst,
    input wire [15:0] cpuAddr,
    input wire        cpuValid,
    input wire        cpuWrite,
    input wire        cpuAckPulse,
    input wire [7:0]  portBOut,
    input wire [7:0]  portFOut,
    input wire        portCOe,
    input wire        rdWrN,
    input wire        selReg,
    input wire        selRam,
    input wire        selEe,
    input wire        selBoot,
    input wire        selExt,
    input wire [15:0] vectorBase,
    input wire        portDOpenDrain,
    input wire [1:0]  modeOut
);
    // ----------------------------------------
    // Decode and bus checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    boot_vec_a:
    assert property (modeOut == 2'h0 |-> vectorBase == 16'hBFC0) else $error("boot vector base");
    open_drain_a:
    assert property (portDOpenDrain == (modeOut == 2'h0)) else $error("port D drive mode");
    no_ext_a:
    assert property (!modeOut[1] |-> !selExt) else $error("external select in chip mode");
    boot_rom_a:
    assert property (modeOut == 2'h0 && cpuValid && cpuAddr[15:8] == 8'hBF |-> selBoot)
        else $error("boot window not claimed");
    rom_off_a:
    assert property (modeOut != 2'h0 |-> !selBoot) else $error("boot rom in normal mode");
    one_sel_a:
    assert property ($onehot0({selReg, selRam, selEe, selBoot, selExt})) else $error("two selects");
    // Address and direction land one cycle after the request is taken
    ext_addr_a:
    assert property ($rose(cpuValid) && selExt |=> {portBOut, portFOut} == $past(cpuAddr)
        && rdWrN == !$past(cpuWrite)) else $error("bus address or direction");
    data_dir_a:
    assert property (portCOe && modeOut[1] |-> !rdWrN) else $error("data driven on read");
    ack_bound_a:
    assert property ($rose(cpuValid) && selExt |-> ##[1:6] cpuAckPulse) else $error("no ack");
    ack_pulse_a:
    assert property (cpuAckPulse |=> !cpuAckPulse) else $error("ack too long");
endmodule // mmd_map_checker

bind mmd_mode_map mmd_map_checker chk (.clk, .rst, .cpuAddr, .cpuValid, .cpuWrite, .cpuAckPulse,
    .portBOut, .portFOut, .portCOe, .rdWrN, .selReg, .selRam, .selEe, .selBoot, .selExt,
    .vectorBase, .portDOpenDrain, .modeOut);

//--- mmd_ext_mem.sv
`timescale 1ns/1ps
// Far-side memory; only the low address byte indexes it, so aliases repeat every 256
module mmd_ext_mem (
    input  wire       clk,
    input  wire [7:0] portFOut,
    input  wire [7:0] portCOut,
    input  wire       portCOe,
    input  wire       rdWrN,
    output wire [7:0] portCIn
);
    logic [7:0] mem [0:255];
    logic [7:0] lastQ = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    // Store on write direction only
    always @(posedge clk) begin
        if (portCOe && !rdWrN) begin
            mem[portFOut] <= portCOut;
        end
        lastQ <= portCIn;
    end
    // Write direction shows the inverse of the last value, not a stale copy
    assign portCIn = rdWrN ? mem[portFOut] : ~lastQ;
endmodule // mmd_ext_mem

//--- tb_mmd_mode_map.sv
`timescale 1ns/1ps
module tb_mmd_mode_map;
    localparam logic [4:0] SREG = 5'h10, SRAM = 5'h08, SEE = 5'h04, SBOOT = 5'h02, SEXT = 5'h01;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, modeSelHigh = 1'b1, modeSelLow = 1'b1;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0, avsWrite = 1'b0, cpuValid = 1'b0, cpuWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0, rdVal;
    logic [15:0] cpuAddr = 16'h0;
    logic [7:0]  cpuWrData = 8'h0, gpioB = 8'h5A, gpioF = 8'hC3, gpioCOut = 8'h00;
    logic        gpioCOe = 1'b0;
    wire  [31:0] avsReadData;
    wire  [15:0] vectorBase;
    wire  [7:0]  cpuRdData, portBOut, portFOut, portCOut, portCIn, gpioCIn;
    wire  [1:0]  modeOut;
    wire         avsWaitRequest, cpuAckPulse, portCOe, rdWrN, selReg, selRam, selEe, selBoot;
    wire         selExt, portDOpenDrain;
    int          errCount = 0, totalChecks = 0, cycleCount = 0;

    mmd_mode_map uut (.clk, .rst, .ce, .modeSelHigh, .modeSelLow, .avsAddress, .avsRead,
        .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .cpuAddr, .cpuValid, .cpuWrite,
        .cpuWrData, .cpuRdData, .cpuAckPulse, .portBOut, .portFOut, .portCOut, .portCOe,
        .portCIn, .gpioB, .gpioF, .gpioCOut, .gpioCOe, .gpioCIn, .rdWrN, .selReg, .selRam,
        .selEe, .selBoot, .selExt, .vectorBase, .portDOpenDrain, .modeOut);
    mmd_ext_mem mem (.clk, .portFOut, .portCOut, .portCOe, .rdWrN, .portCIn);

    // ----------------------------------------
    // Clock, hang guard, shared tasks
    // ----------------------------------------
    always #25 clk = ~clk;
    // A hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            errCount++;
            completeRun();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Straps must stand through the whole reset so both sync stages fill
    task automatic doReset(input logic [1:0] m);
        @(posedge clk);
        rst <= 1'b1;
        {modeSelHigh, modeSelLow} <= m;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(modeOut, m, "captured mode");
    endtask
    task automatic avWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= {24'h0, d};
        avsWrite <= 1'b1;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask
    // Read data are taken at the same edge that samples waitrequest low
    task automatic avRead(input logic [3:0] a);
        @(posedge clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        rdVal = avsReadData;
        avsRead <= 1'b0;
    endtask
    // Valid is held up to the edge that samples the ack, then dropped
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d,
                       input logic [4:0] es, input logic [7:0] er);
        int n;
        @(posedge clk);
        cpuAddr <= a;
        cpuWrite <= w;
        cpuWrData <= d;
        cpuValid <= 1'b1;
        @(negedge clk);
        chk({selReg, selRam, selEe, selBoot, selExt}, es, "decode");
        if (selExt === 1'b1) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (cpuAckPulse !== 1'b1 && n < 20);
            chk(cpuAckPulse, 1'b1, "bus ack");
            if (!w) chk(cpuRdData, er, "bus read data");
        end else begin
            @(posedge clk);
        end
        cpuValid <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testExpanded();
        doReset(2'h3);
        avRead(4'h0);
        chk(rdVal, 32'h01, "map position reset");
        avRead(4'h2);
        chk(rdVal, 32'h0, "unmapped read");
        chk(vectorBase, 16'hFFC0, "normal vectors");
        acc(16'h1000, 0, 0, SREG, 0);
        acc(16'h105F, 0, 0, SREG, 0);
        acc(16'h1060, 0, 0, SEXT, 8'h9F);
        acc(16'h03FF, 0, 0, SRAM, 0);
        acc(16'h0400, 0, 0, SEXT, 8'hFF);
        acc(16'hFE00, 0, 0, SEE, 0);
        acc(16'hBF00, 0, 0, SEXT, 8'hFF);
        avWrite(4'h4, 8'h71);
        avRead(4'h4);
        chk(rdVal, 32'hF1, "config write refused");
        acc(16'h7E00, 0, 0, SEXT, 8'hFF);
    endtask
    task automatic testRemap();
        avWrite(4'h0, 8'h23);
        acc(16'h2000, 0, 0, SRAM, 0);
        acc(16'h3000, 0, 0, SREG, 0);
        acc(16'h1000, 0, 0, SEXT, 8'hFF);
        avWrite(4'h0, 8'h22);
        acc(16'h205F, 0, 0, SREG, 0);
        acc(16'h2060, 0, 0, SRAM, 0);
        acc(16'h4012, 1, 8'hA5, SEXT, 0);
        acc(16'h4012, 0, 0, SEXT, 8'hA5);
    endtask
    task automatic testSingle();
        doReset(2'h1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(portBOut, gpioB, "port B as gpio");
        chk(gpioCIn, 8'h3C, "port C input");
        // Enable low must freeze the port copy even though its source moves
        @(posedge clk);
        ce <= 1'b0;
        gpioB <= 8'hA6;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(portBOut, 8'h5A, "frozen by enable");
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(portBOut, 8'hA6, "enable resumes");
        acc(16'h4000, 0, 0, 5'h00, 0);
        acc(16'h1000, 0, 0, SREG, 0);
        avWrite(4'h4, 8'h71);
        acc(16'hFE00, 0, 0, SEE, 0);
    endtask
    task automatic testTest();
        doReset(2'h2);
        acc(16'hFE00, 0, 0, SEXT, 8'hFF);
        avWrite(4'h4, 8'h71);
        avWrite(4'hC, 8'h01);
        avRead(4'h4);
        chk(rdVal, 32'h71, "config written in test");
        avRead(4'h8);
        chk(rdVal, 32'h049E, "status word");
        acc(16'h7E00, 0, 0, SEE, 0);
        acc(16'hFE00, 0, 0, SEXT, 8'hFF);
    endtask
    task automatic testBoot();
        doReset(2'h0);
        chk(vectorBase, 16'hBFC0, "boot vectors");
        chk(portDOpenDrain, 1'b1, "open drain");
        acc(16'hBF00, 0, 0, SBOOT, 0);
        acc(16'hBF80, 0, 0, SBOOT, 0);
        acc(16'hBFFF, 0, 0, SBOOT, 0);
        acc(16'h03FF, 0, 0, SRAM, 0);
        acc(16'h4000, 0, 0, 5'h00, 0);
        acc(16'hFE00, 0, 0, SEE, 0);
    endtask

    initial begin
        testExpanded();
        testRemap();
        testSingle();
        testTest();
        testBoot();
        completeRun();
    end
endmodule // tb_mmd_mode_map
